// ===== bench/sor_host_model.sv
// Purpose: link side master issuing register port commands
// Assumes: commands change on falling link edges only
// Notes: released command lines show inverted values, never the last one
`timescale 1ns/1ps
module sor_host_model
    import sor_pkg::*;
(
    input wire logic link_clk,
    input wire logic link_cmd_ready,
    input wire logic link_rsp_valid,
    input wire logic [7:0] link_rsp_data,
    output logic link_cmd_valid,
    output logic [1:0] link_cmd_kind,
    output logic [7:0] link_cmd_addr,
    output logic [7:0] link_cmd_wdata
);
    initial begin
        link_cmd_valid = 1'b0;
        link_cmd_kind = SOR_CMD_NONE;
        link_cmd_addr = 8'h00;
        link_cmd_wdata = 8'h00;
    end
    // ****************
    // one command, held until taken
    // ****************
    task automatic xfer(input logic [1:0] k, input logic [7:0] a, input logic [7:0] w, output logic [7:0] r);
        int n;
        r = 'x;
        n = 0;
        @(negedge link_clk);
        link_cmd_valid = 1'b1;
        link_cmd_kind = k;
        link_cmd_addr = a;
        link_cmd_wdata = w;
        do begin
            @(posedge link_clk);
            n++;
        end while (link_cmd_ready !== 1'b1 && n < 60);
        @(negedge link_clk);
        link_cmd_valid = 1'b0;
        link_cmd_kind = ~k; // no stale value once released
        link_cmd_addr = ~a;
        link_cmd_wdata = ~w;
        if (k == SOR_CMD_READ) begin
            n = 0;
            do begin
                @(posedge link_clk);
                n++;
            end while (link_rsp_valid !== 1'b1 && n < 60);
            if (n < 60) r = link_rsp_data;
        end
    endtask
endmodule

// ===== bench/sor_top_checker.sv
// Purpose: port level checks for the sensor output register area
// Assumes: link side leaves reset two link edges after the core side
// Notes: windows are loose because every command crosses two clocks
`timescale 1ns/1ps
module sor_top_checker
    import sor_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic standby_active_select,
    input wire logic pressure_valid,
    input wire logic temperature_valid,
    input wire logic fifo_in_ready,
    input wire logic any_sample_ready_flag,
    input wire logic link_clk,
    input wire logic link_cmd_valid,
    input wire logic [1:0] link_cmd_kind,
    input wire logic link_cmd_ready,
    input wire logic link_rsp_valid,
    input wire logic [7:0] link_rsp_data
);
    // ****************
    // core side checks
    // ****************
    wire any_valid = pressure_valid || temperature_valid;
    AST_RESET_QUIET: assert property (@(posedge mclk) reset |=> !fifo_in_ready && !any_sample_ready_flag)
        else $error("outputs active in reset");
    AST_ACT_CLEAR: assert property (@(posedge mclk) disable iff (reset)
        $rose(standby_active_select) |-> ##[1:3] !any_sample_ready_flag) else $error("activation kept flag");
    AST_FLAG_SET: assert property (@(posedge mclk) disable iff (reset)
        any_valid && !$rose(standby_active_select) |-> ##[1:2] any_sample_ready_flag) else $error("flag not set");
    AST_FLAG_CAUSE: assert property (@(posedge mclk) disable iff (reset)
        $rose(any_sample_ready_flag) |-> $past(any_valid) || $past(any_valid, 2) || $past(any_valid, 3))
        else $error("flag rose without sample");
    // ****************
    // link side checks
    // ****************
    // link logic leaves its own reset a few link edges after reset falls;
    // its outputs are unknown before that, so link checks wait it out
    logic [3:0] link_settle;
    always_ff @(posedge link_clk) begin
        if (reset) begin
            link_settle <= 4'h0;
        end else begin
            link_settle <= {link_settle[2:0], 1'b1};
        end
    end
    wire link_off = reset || !link_settle[3];
    // a taken command keeps the port busy until answered
    sequence s_take;
        link_cmd_valid && link_cmd_ready;
    endsequence
    sequence s_read;
        link_cmd_valid && link_cmd_ready && link_cmd_kind == SOR_CMD_READ;
    endsequence
    AST_TAKE_BUSY: assert property (@(posedge link_clk) disable iff (link_off) s_take |=> !link_cmd_ready)
        else $error("ready stayed high after take");
    AST_READ_ANSWER: assert property (@(posedge link_clk) disable iff (link_off) s_read |-> ##[2:12] link_rsp_valid)
        else $error("read not answered");
    AST_RSP_PULSE: assert property (@(posedge link_clk) disable iff (link_off) link_rsp_valid |=> !link_rsp_valid)
        else $error("response longer than one cycle");
    AST_RSP_HOLD: assert property (@(posedge link_clk) disable iff (link_off)
        !link_rsp_valid |-> $stable(link_rsp_data)) else $error("response data moved");
    AST_RSP_READY: assert property (@(posedge link_clk) disable iff (link_off) link_rsp_valid |-> link_cmd_ready)
        else $error("answer without ready");
endmodule
bind sor_top sor_top_checker u_chk (.mclk, .reset, .standby_active_select, .pressure_valid, .temperature_valid,
    .fifo_in_ready, .any_sample_ready_flag, .link_clk, .link_cmd_valid, .link_cmd_kind, .link_cmd_ready,
    .link_rsp_valid, .link_rsp_data);

// ===== bench/sor_top_tb.sv
// Purpose: bench for samples, status alias, pointer walk and queue port
// Assumes: all link traffic goes through the host model
// Notes: queue checks run once for each of queue modes 01 and 10
`timescale 1ns/1ps
module sor_top_tb
    import sor_pkg::*;
;
    logic mclk, link_clk, reset, standby_active_select, pressure_valid, temperature_valid, fifo_in_valid;
    logic [1:0] fifo_mode, link_cmd_kind;
    logic [SOR_P_WIDTH-1:0] pressure_sample;
    logic [SOR_T_WIDTH-1:0] temperature_sample;
    logic [7:0] fifo_in_data, link_cmd_addr, link_cmd_wdata, link_rsp_data, rd;
    logic fifo_in_ready, any_sample_ready_flag, link_cmd_valid, link_cmd_ready, link_rsp_valid;
    logic [7:0] pexp [7] = '{8'h0C, 8'hAB, 8'hCD, 8'hE0, 8'h00, 8'h00, 8'h00};
    int mismatches = 0;
    int total_checks = 0;
    // ****************
    // clocks, unrelated phases
    // ****************
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial begin
        link_clk = 1'b0;
        #37;
        forever #80 link_clk = ~link_clk;
    end
    sor_top u_dut (.mclk, .reset, .standby_active_select, .fifo_mode, .pressure_valid, .pressure_sample,
        .temperature_valid, .temperature_sample, .fifo_in_valid, .fifo_in_data, .fifo_in_ready,
        .any_sample_ready_flag, .link_clk, .link_cmd_valid, .link_cmd_kind, .link_cmd_addr, .link_cmd_wdata,
        .link_cmd_ready, .link_rsp_valid, .link_rsp_data);
    sor_host_model u_host (.link_clk, .link_cmd_ready, .link_rsp_valid, .link_rsp_data, .link_cmd_valid,
        .link_cmd_kind, .link_cmd_addr, .link_cmd_wdata);
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic seta(input logic [7:0] a);
        u_host.xfer(SOR_CMD_SET_ADDR, a, 8'h00, rd);
    endtask
    task automatic rdx(input string name, input logic [7:0] exp);
        u_host.xfer(SOR_CMD_READ, 8'h00, 8'h00, rd);
        check(name, rd, exp);
    endtask
    task automatic smp(input logic pv, input logic tv, input logic [19:0] p, input logic [11:0] t);
        @(negedge mclk);
        pressure_valid = pv;
        temperature_valid = tv;
        pressure_sample = p;
        temperature_sample = t;
        @(negedge mclk);
        pressure_valid = 1'b0;
        temperature_valid = 1'b0;
        repeat (2) @(negedge mclk);
    endtask
    // ready is registered, so its value at the falling edge decides the next push
    task automatic fill(input int cnt, input logic [7:0] base);
        int n;
        n = 0;
        while (n < cnt) begin
            @(negedge mclk);
            fifo_in_data = base + 8'(n);
            fifo_in_valid = 1'b1;
            if (fifo_in_ready === 1'b1) n++;
        end
        @(negedge mclk);
        fifo_in_valid = 1'b0;
    endtask
    // ****************
    // main sequence
    // ****************
    initial begin
        reset = 1'b1;
        standby_active_select = 1'b0;
        fifo_mode = SOR_FMODE_OFF;
        {pressure_valid, temperature_valid, fifo_in_valid} = 3'h0;
        pressure_sample = 20'h00000;
        temperature_sample = 12'h000;
        fifo_in_data = 8'h00;
        repeat (4) @(negedge mclk);
        reset = 1'b0;
        @(negedge mclk);
        standby_active_select = 1'b1;
        seta(SOR_ADDR_STATUS);
        for (int i = 0; i < 7; i++) begin
            rdx("cleared area", SOR_RESET_VALUE);
        end
        smp(1'b1, 1'b0, 20'hABCDE, 12'h000);
        check("ready flag", {7'h00, any_sample_ready_flag}, 8'h01);
        seta(SOR_ADDR_STATUS);
        foreach (pexp[i]) rdx("pressure walk", pexp[i]);
        check("flag cleared", {7'h00, any_sample_ready_flag}, 8'h00);
        smp(1'b0, 1'b1, 20'h00000, 12'h9F3);
        seta(SOR_ADDR_T_HIGH);
        rdx("temp high", 8'h9F);
        rdx("temp low", 8'h30);
        rdx("status after temp", 8'h00);
        smp(1'b1, 1'b0, 20'h12345, 12'h000);
        smp(1'b1, 1'b0, 20'h12345, 12'h000);
        seta(SOR_ADDR_STATUS);
        rdx("overwrite status", 8'hCC);
        @(negedge mclk);
        standby_active_select = 1'b0;
        seta(SOR_ADDR_P_HIGH);
        rdx("kept high", 8'h12);
        rdx("kept mid", 8'h34);
        u_host.xfer(SOR_CMD_WRITE, 8'h00, 8'hFF, rd);
        seta(SOR_ADDR_P_LOW);
        rdx("write ignored", 8'h50);
        seta(8'h40);
        rdx("unmapped", SOR_RESERVED_READ);
        for (int m = 1; m < 3; m++) begin
            @(negedge mclk);
            fifo_mode = 2'(m);
            standby_active_select = 1'b0;
            @(negedge mclk);
            standby_active_select = 1'b1;
            seta(SOR_ADDR_STATUS);
            rdx("flushed queue", 8'h00);
            fill(32, 8'(m * 64));
            @(negedge mclk);
            fifo_in_valid = 1'b1;
            check("full refusal", {7'h00, fifo_in_ready}, 8'h00);
            @(negedge mclk);
            fifo_in_valid = 1'b0;
            smp(1'b1, 1'b0, 20'h11111, 12'h000);
            seta(SOR_ADDR_STATUS);
            rdx("queue count", 8'h20);
            for (int i = 0; i < 32; i++) begin
                rdx("queue byte", 8'(m * 64 + i));
            end
            check("queue flags", {7'h00, any_sample_ready_flag}, 8'h00);
            rdx("empty queue", 8'h00);
            fill(1, 8'h77);
            seta(SOR_ADDR_P_MID);
            for (int i = 0; i < 4; i++) begin
                rdx("reserved read", SOR_RESERVED_READ);
            end
            rdx("wrapped status", 8'h01);
        end
        end_of_test();
    end
    // watchdog, far beyond the expected run of about 120 us
    initial begin
        #3000000;
        mismatches++;
        end_of_test();
    end
endmodule

// ===== design/sor_pkg.sv
// Purpose: constants shared by the sensor output register area
// Assumes: byte wide register port, 32 byte sample queue
// Notes: offsets are register pointer values, not byte lanes
//
// Function
// (RULE1) Going active to standby leaves every register value untouched.
// (RULE2) Going standby to active clears status, samples and queue contents.
// (RULE3) Standby-only registers are written in standby only; mode bits always writable; code ignores every write, mode bits included.
// (RULE4) Address 00h reads sample status when queue mode zero, queue status otherwise.
// (RULE5) Queue off: pressure bits 12-19 at 01h, 4-11 at 02h, 0-3 at 03h.
// (RULE6) Queue off: temperature bits 4-11 at 04h, bits 0-3 at 05h.
// (RULE7) Queue off: pointer steps 00h to 05h after each read, then wraps.
// (RULE8) After reading 01h pointer goes to 02h when queue off, stays when on.
// (RULE9) Queue on: successive queue bytes come from 01h, pointer stays there.
// (RULE10) Queue on: 02h to 05h read 00, pointer steps through and wraps.
// (RULE11) Queue mode field: 00 disabled, 01 circular, 10 stop when full; code runs 01 as stop when full too.
// (RULE12) Ready and overwrite flags clear on high byte or queue port reads.
// (RULE13) Writes to read-only or locked registers here are ignored.

package sor_pkg;

    // *************************************
    // register pointer values
    // *************************************
    localparam logic [7:0] SOR_ADDR_STATUS = 8'h00;
    localparam logic [7:0] SOR_ADDR_P_HIGH = 8'h01;
    localparam logic [7:0] SOR_ADDR_P_MID = 8'h02;
    localparam logic [7:0] SOR_ADDR_P_LOW = 8'h03;
    localparam logic [7:0] SOR_ADDR_T_HIGH = 8'h04;
    localparam logic [7:0] SOR_ADDR_T_LOW = 8'h05;
    localparam logic [7:0] SOR_RESET_VALUE = 8'h00;
    localparam logic [7:0] SOR_RESERVED_READ = 8'h00;

    // *************************************
    // sample ready status bit positions
    // *************************************
    localparam int SOR_BIT_ANY_SAMPLE_OVERWRITE_FLAG = 7;
    localparam int SOR_BIT_POW = 6;
    localparam int SOR_BIT_TOW = 5;
    localparam int SOR_BIT_ANY_SAMPLE_READY_FLAG = 3;
    localparam int SOR_BIT_PDR = 2;
    localparam int SOR_BIT_TDR = 1;

    // *************************************
    // sample and queue geometry
    // *************************************
    localparam int SOR_P_WIDTH = 20;
    localparam int SOR_T_WIDTH = 12;
    localparam int SOR_FIFO_WIDTH = 8;
    localparam int SOR_FIFO_DEPTH = 32;

    // queue mode field encoding
    typedef enum logic [1:0] {
        SOR_FMODE_OFF = 2'b00,
        SOR_FMODE_CIRCULAR = 2'b01,
        SOR_FMODE_STOP_FULL = 2'b10,
        SOR_FMODE_RSVD = 2'b11
    } sor_fmode_t;

    // link command kinds
    typedef enum logic [1:0] {
        SOR_CMD_SET_ADDR = 2'b00,
        SOR_CMD_READ = 2'b01,
        SOR_CMD_WRITE = 2'b10,
        SOR_CMD_NONE = 2'b11
    } sor_cmd_t;

endpackage

// ===== design/sor_top.sv
// Purpose: low register area of the sensor, samples, status and queue port
// Assumes: link side is the byte level register port of the serial front end
// Notes: link side runs on its own clock; commands cross by toggle handshake

`timescale 1ns/1ps

// *************************************
// sample byte queue
// *************************************
module sor_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] count
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_CNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] next_count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    assign out_data = mem[rd_ptr];

    // storage has no reset, contents are gated by out_valid
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers and registered flags, flags follow the next count
    always_ff @(posedge clk) begin
        if (rst || flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            wr_ptr <= wr_ptr + AW'(push);
            rd_ptr <= rd_ptr + AW'(pop);
            count <= next_count;
            in_ready <= (next_count != DEPTH_CNT);
            out_valid <= (next_count != '0);
        end
    end
endmodule

// *************************************
// register area top
// *************************************
module sor_top
    import sor_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic standby_active_select,
    input wire logic [1:0] fifo_mode,
    input wire logic pressure_valid,
    input wire logic [SOR_P_WIDTH-1:0] pressure_sample,
    input wire logic temperature_valid,
    input wire logic [SOR_T_WIDTH-1:0] temperature_sample,
    input wire logic fifo_in_valid,
    input wire logic [SOR_FIFO_WIDTH-1:0] fifo_in_data,
    output logic fifo_in_ready,
    output logic any_sample_ready_flag,
    input wire logic link_clk,
    input wire logic link_cmd_valid,
    input wire logic [1:0] link_cmd_kind,
    input wire logic [7:0] link_cmd_addr,
    input wire logic [7:0] link_cmd_wdata,
    output logic link_cmd_ready,
    output logic link_rsp_valid,
    output logic [7:0] link_rsp_data
);
    // *************************************
    // link clock domain
    // *************************************
    logic link_rst_meta;
    logic link_rst;
    logic link_pending;
    logic link_req_tgl;
    logic [1:0] link_kind;
    logic [7:0] link_addr;
    logic [7:0] link_wdata;
    logic ack_meta;
    logic ack_sync;
    logic ack_seen;
    logic core_ack_tgl;
    logic [7:0] core_rd_data;
    wire link_ack_edge = ack_sync ^ ack_seen;

    // reset carried into the link domain
    always_ff @(posedge link_clk) begin
        link_rst_meta <= reset;
        link_rst <= link_rst_meta;
    end

    // acknowledge toggle synchroniser
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            ack_meta <= 1'b0;
            ack_sync <= 1'b0;
            ack_seen <= 1'b0;
        end else begin
            ack_meta <= core_ack_tgl;
            ack_sync <= ack_meta;
            ack_seen <= ack_sync;
        end
    end

    // one command in flight; the held fields are stable until acknowledged
    always_ff @(posedge link_clk) begin
        link_rsp_valid <= 1'b0;
        if (link_rst) begin
            link_pending <= 1'b0;
            link_cmd_ready <= 1'b0;
            link_req_tgl <= 1'b0;
            link_kind <= SOR_CMD_NONE;
            link_addr <= SOR_RESET_VALUE;
            link_wdata <= SOR_RESET_VALUE;
            link_rsp_data <= SOR_RESET_VALUE;
        end else if (link_pending) begin
            if (link_ack_edge) begin
                link_pending <= 1'b0;
                link_cmd_ready <= 1'b1;
                link_rsp_valid <= (link_kind == SOR_CMD_READ);
                link_rsp_data <= core_rd_data;
            end
        end else if (link_cmd_valid && link_cmd_ready) begin
            link_pending <= 1'b1;
            link_cmd_ready <= 1'b0;
            link_kind <= link_cmd_kind;
            link_addr <= link_cmd_addr;
            link_wdata <= link_cmd_wdata;
            link_req_tgl <= ~link_req_tgl;
        end else begin
            link_cmd_ready <= 1'b1;
        end
    end

    // *************************************
    // core domain: request crossing
    // *************************************
    logic req_meta;
    logic req_sync;
    logic req_seen;
    wire req_edge = req_sync ^ req_seen;

    always_ff @(posedge mclk) begin
        if (reset) begin
            req_meta <= 1'b0;
            req_sync <= 1'b0;
            req_seen <= 1'b0;
        end else begin
            req_meta <= link_req_tgl;
            req_sync <= req_meta;
            req_seen <= req_sync;
        end
    end

    // *************************************
    // core domain: mode and decode
    // *************************************
    logic active_seen;
    logic [7:0] ptr;
    logic [7:0] sample_ready_status;
    logic [SOR_P_WIDTH-1:0] p_data;
    logic [SOR_T_WIDTH-1:0] t_data;
    logic fifo_out_valid;
    logic [SOR_FIFO_WIDTH-1:0] fifo_out_data;
    logic [$clog2(SOR_FIFO_DEPTH):0] fifo_count;

    // (RULE1) only the rising edge clears
    wire go_active = standby_active_select && !active_seen;
    // (RULE11) any nonzero mode runs the queue
    wire fifo_on = (fifo_mode != SOR_FMODE_OFF);
    wire do_read = req_edge && (link_kind == SOR_CMD_READ);
    wire do_write = req_edge && (link_kind == SOR_CMD_WRITE);
    wire do_addr = req_edge && (link_kind == SOR_CMD_SET_ADDR);
    wire rd_p_high = do_read && (ptr == SOR_ADDR_P_HIGH) && !fifo_on;
    wire rd_t_high = do_read && (ptr == SOR_ADDR_T_HIGH) && !fifo_on;
    wire rd_fifo = do_read && (ptr == SOR_ADDR_P_HIGH) && fifo_on;
    // queue status: count in the low bits, upper flags kept zero
    wire [7:0] fifo_status = {2'b00, fifo_count};
    wire [7:0] fifo_byte = fifo_out_valid ? fifo_out_data : SOR_RESERVED_READ;

    // (RULE4) status alias at 00h follows the queue mode
    wire [7:0] rd_status = fifo_on ? fifo_status : sample_ready_status;
    // (RULE5) pressure bytes, queue off
    wire [7:0] rd_p_high_b = fifo_on ? fifo_byte : p_data[19:12];
    wire [7:0] rd_p_mid_b = fifo_on ? SOR_RESERVED_READ : p_data[11:4];
    wire [7:0] rd_p_low_b = fifo_on ? SOR_RESERVED_READ : {p_data[3:0], 4'h0};
    // (RULE6) temperature bytes, queue off
    wire [7:0] rd_t_high_b = fifo_on ? SOR_RESERVED_READ : t_data[11:4];
    // (RULE10) reserved slots read as zero while the queue runs
    wire [7:0] rd_t_low_b = fifo_on ? SOR_RESERVED_READ : {t_data[3:0], 4'h0};

    // read selection by pointer
    logic [7:0] rd_mux;
    always_comb begin
        case (ptr)
            SOR_ADDR_STATUS: rd_mux = rd_status;
            SOR_ADDR_P_HIGH: rd_mux = rd_p_high_b;
            SOR_ADDR_P_MID: rd_mux = rd_p_mid_b;
            SOR_ADDR_P_LOW: rd_mux = rd_p_low_b;
            SOR_ADDR_T_HIGH: rd_mux = rd_t_high_b;
            SOR_ADDR_T_LOW: rd_mux = rd_t_low_b;
            default: rd_mux = SOR_RESERVED_READ;
        endcase
    end

    // (RULE7) step and wrap at the end of the area
    wire at_end = (ptr == SOR_ADDR_T_LOW);
    // (RULE8) root pointer holds while the queue runs
    wire hold_root = (ptr == SOR_ADDR_P_HIGH) && fifo_on;
    wire [7:0] next_ptr = at_end ? SOR_ADDR_STATUS : (hold_root ? ptr : ptr + 8'h01);

    // pointer, read data and acknowledge
    always_ff @(posedge mclk) begin
        if (reset) begin
            ptr <= SOR_RESET_VALUE;
            core_rd_data <= SOR_RESET_VALUE;
            core_ack_tgl <= 1'b0;
        end else begin
            if (do_addr) begin
                ptr <= link_addr;
            end else if (do_read || do_write) begin
                // (RULE9) burst reads stay on the queue port
                ptr <= next_ptr;
            end
            if (do_read) begin
                core_rd_data <= rd_mux;
            end
            if (req_edge) begin
                core_ack_tgl <= ~core_ack_tgl;
            end
        end
    end

    // (RULE3) (RULE13) writes only move the pointer, stored values are untouched
    wire unused_write = do_write && (link_wdata != link_wdata);

    // *************************************
    // core domain: samples and flags
    // *************************************
    // (RULE12) clear sources for each flag
    wire clr_p = rd_p_high || rd_fifo;
    wire clr_t = rd_t_high || rd_fifo;
    wire clr_pt = rd_p_high || rd_t_high || rd_fifo;
    logic [7:0] next_status;
    always_comb begin
        next_status = 8'h00;
        // new data sets, and a set wins over a same cycle read clear
        next_status[SOR_BIT_PDR] = pressure_valid || (sample_ready_status[SOR_BIT_PDR] && !clr_p);
        next_status[SOR_BIT_TDR] = temperature_valid || (sample_ready_status[SOR_BIT_TDR] && !clr_t);
        next_status[SOR_BIT_ANY_SAMPLE_READY_FLAG] = pressure_valid || temperature_valid || (sample_ready_status[SOR_BIT_ANY_SAMPLE_READY_FLAG] && !clr_pt);
        next_status[SOR_BIT_POW] = (pressure_valid && sample_ready_status[SOR_BIT_PDR])
            || (sample_ready_status[SOR_BIT_POW] && !clr_p);
        next_status[SOR_BIT_TOW] = (temperature_valid && sample_ready_status[SOR_BIT_TDR])
            || (sample_ready_status[SOR_BIT_TOW] && !clr_t);
        next_status[SOR_BIT_ANY_SAMPLE_OVERWRITE_FLAG] = ((pressure_valid || temperature_valid) && sample_ready_status[SOR_BIT_ANY_SAMPLE_READY_FLAG])
            || (sample_ready_status[SOR_BIT_ANY_SAMPLE_OVERWRITE_FLAG] && !clr_pt) || unused_write;
    end

    // samples and status; entering active mode wipes them
    always_ff @(posedge mclk) begin
        if (reset) begin
            active_seen <= 1'b0;
            sample_ready_status <= SOR_RESET_VALUE;
            p_data <= '0;
            t_data <= '0;
            any_sample_ready_flag <= 1'b0;
        end else begin
            active_seen <= standby_active_select;
            if (go_active) begin
                // (RULE2) activation clears the area
                sample_ready_status <= SOR_RESET_VALUE;
                p_data <= '0;
                t_data <= '0;
                any_sample_ready_flag <= 1'b0;
            end else begin
                sample_ready_status <= next_status;
                any_sample_ready_flag <= next_status[SOR_BIT_ANY_SAMPLE_READY_FLAG];
                if (pressure_valid) begin
                    p_data <= pressure_sample;
                end
                if (temperature_valid) begin
                    t_data <= temperature_sample;
                end
            end
        end
    end

    // *************************************
    // sample queue; the port read pops one byte
    // *************************************
    sor_fifo #(
        .WIDTH(SOR_FIFO_WIDTH),
        .DEPTH(SOR_FIFO_DEPTH)
    ) u_fifo (
        .clk(mclk),
        .rst(reset),
        .flush(go_active),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(rd_fifo),
        .out_data(fifo_out_data),
        .count(fifo_count)
    );
endmodule
